// ==== verilog/rbis_seq.sv ====
// reset, power-down and boot initialisation sequencer
`timescale 1ns/1ps
`include "rbis_cfg.svh"

// Functional notes
// - while reset is low, ignore all I2C and serial audio traffic
// - I2C lines stay released from reset until initialisation completes
// - reset release starts memory clearing and register default loading
// - after housekeeping enable master I2C, keep slave I2C disabled
// - probe for boot EEPROM on master port before any other path
// - clock halt input stops device clocks while keeping all state
// - address select input picks one of two slave/master address pairs
// - strap pin is an input after any reset; only firmware or the failed-boot fallback changes it
// - failed boot with strap high: default config, serial outputs inactive
// - strap-high fallback: update status, enable slave, then drive strap low
// - memory read error during load is recorded in load status register
// - failed boot with strap low: status, slave enable, serial pass-through
// - test mode drives strap low; no-EEPROM load ends about 100 ms after reset (here a not-found probe ends it at once, only a silent one times out)
// - after good boot or slave download firmware sets strap direction
// - any reset idles the DSP core and starts the microcontroller init
// - internal supply monitors also put the device in reset
module rbis_seq #(
    parameter int LOAD_TMO_CYC = `RBIS_LOAD_TMO_CYC,
    parameter int MEM_DEPTH    = `RBIS_MEM_DEPTH,
    parameter int SDIO_N       = `RBIS_SDIO_N
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire logic                   supply_ok_b,
    input  wire logic                   clock_halt_input_b,
    input  wire logic                   address_select_pin,
    input  wire logic                   strap_in,
    input  wire rbis_pkg::rbis_boot_res_t boot_res,
    input  wire logic                   slave_dl_done,
    input  wire logic                   fw_strap_oe,
    input  wire logic                   fw_strap_out,
    input  wire logic [SDIO_N-1:0]      serial_audio_in,
    input  wire logic [SDIO_N-1:0]      core_audio_out,
    input  wire logic [`RBIS_SUB_W-1:0] sub_addr,
    output logic [31:0]                 sub_rd_data,
    output logic [SDIO_N-1:0]           serial_audio_out,
    output logic                        strap_out,
    output logic                        strap_oe,
    output logic                        master_en,
    output logic                        slave_en,
    output logic [6:0]                  slave_addr,
    output logic [6:0]                  master_addr,
    output logic                        clk_run,
    output logic                        core_idle,
    output logic                        mcu_init,
    output logic                        mem_clr_we,
    output logic [$clog2(MEM_DEPTH)-1:0] mem_clr_addr,
    output logic                        regs_default
);
    import rbis_pkg::*;

    localparam int AW = $clog2(MEM_DEPTH);
    localparam int TW = $clog2(LOAD_TMO_CYC + 1);
    localparam int SN = SDIO_N + 3;
    localparam logic [AW-1:0] LAST_ADDR = AW'(MEM_DEPTH - 1);
    localparam logic [TW-1:0] TMO_LAST  = TW'(LOAD_TMO_CYC - 1);
    // halt pin idles high; a zero here would read as a false halt just after reset
    localparam logic [SN-1:0] SYNC_IDLE = SN'(1'b1);

    // supply monitors share the reset path
    logic rst_all_b;
    assign rst_all_b = rst_b & supply_ok_b;

    // pin synchronisers, first stage read only by the second
    logic [SN-1:0] sync1_reg;
    logic [SN-1:0] sync2_reg;
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= {serial_audio_in, strap_in, address_select_pin, clock_halt_input_b};
            sync2_reg <= sync1_reg;
        end
    end

    logic              halt_s;
    logic              asel_s;
    logic              strap_s;
    logic [SDIO_N-1:0] sdin_s;
    assign halt_s  = ~sync2_reg[0];
    assign asel_s  = sync2_reg[1];
    assign strap_s = sync2_reg[2];
    assign sdin_s  = sync2_reg[SN-1:3];

    rbis_state_t       state_reg, state_next;
    logic [AW-1:0]     addr_reg, addr_next;
    logic [AW-1:0]     caddr_reg, caddr_next;
    logic [TW-1:0]     tmo_reg, tmo_next;
    logic              strap_lvl_reg, strap_lvl_next;
    logic              err_reg, err_next;
    logic              found_reg, found_next;
    logic [31:0]       stat_reg, stat_next;
    logic [31:0]       rd_reg, rd_next;
    logic [SDIO_N-1:0] sdo_reg, sdo_next;
    logic              s_oe_reg, s_oe_next;
    logic              s_out_reg, s_out_next;
    logic              mst_reg, mst_next;
    logic              slv_reg, slv_next;
    logic [6:0]        saddr_reg, saddr_next;
    logic [6:0]        maddr_reg, maddr_next;
    logic              run_reg, run_next;
    logic              idle_reg, idle_next;
    logic              mcu_reg, mcu_next;
    logic              we_reg, we_next;
    logic              dflt_reg, dflt_next;

    always_comb begin
        state_next     = state_reg;
        addr_next      = addr_reg;
        // clear address trails the counter so it lines up with the registered strobe
        caddr_next     = addr_reg;
        tmo_next       = tmo_reg;
        strap_lvl_next = strap_lvl_reg;
        err_next       = err_reg;
        found_next     = found_reg;
        stat_next      = stat_reg;
        sdo_next       = sdo_reg;
        s_oe_next      = s_oe_reg;
        s_out_next     = s_out_reg;
        mst_next       = mst_reg;
        slv_next       = slv_reg;
        run_next       = ~halt_s;
        idle_next      = idle_reg;
        mcu_next       = 1'b0;
        we_next        = 1'b0;
        dflt_next      = 1'b0;
        saddr_next     = asel_s ? `RBIS_SLV_ADDR_B : `RBIS_SLV_ADDR_A;
        maddr_next     = asel_s ? `RBIS_MST_ADDR_B : `RBIS_MST_ADDR_A;
        // reads answer only once the slave port is on
        rd_next = (slv_reg && sub_addr == `RBIS_LOAD_STATUS) ? stat_reg : 32'h0000_0000;
        if (!halt_s) begin
            case (state_reg)
                RBIS_S_IDLE: begin
                    // first edge after reset release
                    state_next = RBIS_S_CLEAR;
                    mcu_next   = 1'b1;
                    addr_next  = '0;
                    dflt_next  = 1'b1;
                end
                RBIS_S_CLEAR: begin
                    we_next        = 1'b1;
                    strap_lvl_next = strap_s;
                    if (addr_reg == LAST_ADDR) begin
                        state_next = RBIS_S_PROBE;
                        mst_next   = 1'b1;
                        tmo_next   = '0;
                    end else begin
                        addr_next = addr_reg + AW'(1);
                    end
                end
                RBIS_S_PROBE: begin
                    // nothing else may configure the part until the probe ends
                    tmo_next = tmo_reg + TW'(1);
                    if (boot_res.rd_err) begin
                        err_next   = 1'b1;
                        found_next = 1'b1;
                        state_next = RBIS_S_STAT;
                    end else if (boot_res.load_done) begin
                        found_next = 1'b1;
                        state_next = RBIS_S_STAT;
                    end else if (boot_res.probe_done && !boot_res.found) begin
                        state_next = RBIS_S_STAT;
                    end else if (tmo_reg == TMO_LAST) begin
                        state_next = RBIS_S_STAT;
                    end
                end
                RBIS_S_STAT: begin
                    stat_next = 32'h0000_0000;
                    stat_next[`RBIS_ST_FOUND]  = found_reg;
                    stat_next[`RBIS_ST_RD_ERR] = err_reg;
                    stat_next[`RBIS_ST_DONE]   = 1'b1;
                    stat_next[`RBIS_ST_STRAP]  = strap_lvl_reg;
                    stat_next[`RBIS_ST_TEST]   = ~(found_reg & ~err_reg) & ~strap_lvl_reg;
                    stat_next[`RBIS_ST_BOOTED] = found_reg & ~err_reg;
                    state_next = RBIS_S_SLV;
                end
                RBIS_S_SLV: begin
                    slv_next   = 1'b1;
                    state_next = stat_reg[`RBIS_ST_BOOTED] ? RBIS_S_RUN : RBIS_S_DRIVE;
                end
                RBIS_S_DRIVE: begin
                    s_oe_next  = 1'b1;
                    s_out_next = 1'b0;
                    state_next = RBIS_S_FALL;
                end
                RBIS_S_FALL: begin
                    if (strap_lvl_reg) begin
                        sdo_next = '0;
                    end else begin
                        sdo_next = sdin_s;
                    end
                    if (slave_dl_done) begin
                        state_next = RBIS_S_RUN;
                    end
                end
                RBIS_S_RUN: begin
                    idle_next  = 1'b0;
                    sdo_next   = core_audio_out;
                    s_oe_next  = fw_strap_oe;
                    s_out_next = fw_strap_out;
                end
                default: begin
                    state_next = RBIS_S_IDLE;
                end
            endcase
        end
    end

    // reset alone quiets every port, lines released, strap an input
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            state_reg     <= RBIS_S_IDLE;
            addr_reg      <= '0;
            caddr_reg     <= '0;
            tmo_reg       <= '0;
            strap_lvl_reg <= 1'b0;
            err_reg       <= 1'b0;
            found_reg     <= 1'b0;
            stat_reg      <= 32'h0000_0000;
            rd_reg        <= 32'h0000_0000;
            sdo_reg       <= '0;
            s_oe_reg      <= 1'b0;
            s_out_reg     <= 1'b0;
            mst_reg       <= 1'b0;
            slv_reg       <= 1'b0;
            saddr_reg     <= `RBIS_SLV_ADDR_A;
            maddr_reg     <= `RBIS_MST_ADDR_A;
            run_reg       <= 1'b1;
            idle_reg      <= 1'b1;
            mcu_reg       <= 1'b0;
            we_reg        <= 1'b0;
            dflt_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            addr_reg      <= addr_next;
            caddr_reg     <= caddr_next;
            tmo_reg       <= tmo_next;
            strap_lvl_reg <= strap_lvl_next;
            err_reg       <= err_next;
            found_reg     <= found_next;
            stat_reg      <= stat_next;
            rd_reg        <= rd_next;
            sdo_reg       <= sdo_next;
            s_oe_reg      <= s_oe_next;
            s_out_reg     <= s_out_next;
            mst_reg       <= mst_next;
            slv_reg       <= slv_next;
            saddr_reg     <= saddr_next;
            maddr_reg     <= maddr_next;
            run_reg       <= run_next;
            idle_reg      <= idle_next;
            mcu_reg       <= mcu_next;
            we_reg        <= we_next;
            dflt_reg      <= dflt_next;
        end
    end

    assign sub_rd_data      = rd_reg;
    assign serial_audio_out = sdo_reg;
    assign strap_out        = s_out_reg;
    assign strap_oe         = s_oe_reg;
    assign master_en        = mst_reg;
    assign slave_en         = slv_reg;
    assign slave_addr       = saddr_reg;
    assign master_addr      = maddr_reg;
    assign clk_run          = run_reg;
    assign core_idle        = idle_reg;
    assign mcu_init         = mcu_reg;
    assign mem_clr_we       = we_reg;
    assign mem_clr_addr     = caddr_reg;
    assign regs_default     = dflt_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_all_b);

    sequence seq_fall_steps;
        state_reg == RBIS_S_STAT ##1 state_reg == RBIS_S_SLV ##1 state_reg == RBIS_S_DRIVE;
    endsequence

    a_clear_quiet: assert property (
        state_reg == RBIS_S_CLEAR |-> !mst_reg && !slv_reg && !s_oe_reg)
        else $error("port enabled during housekeeping");
    a_master_after: assert property (
        state_reg == RBIS_S_CLEAR && addr_reg == LAST_ADDR && !halt_s
        |=> mst_reg && !slv_reg && state_reg == RBIS_S_PROBE)
        else $error("master port not enabled after clear");
    a_fall_order: assert property (
        state_reg == RBIS_S_STAT && !halt_s && !stat_next[`RBIS_ST_BOOTED]
        ##1 !halt_s ##1 !halt_s
        |=> $past(slv_reg) && s_oe_reg && !s_out_reg && stat_reg[`RBIS_ST_DONE])
        else $error("strap driven before status and slave enable");
    a_fall_seq: assert property (
        seq_fall_steps |-> slv_reg && stat_reg[`RBIS_ST_DONE] && !s_oe_reg)
        else $error("fallback steps out of order");
    a_strap_input: assert property (
        state_reg inside {RBIS_S_IDLE, RBIS_S_CLEAR, RBIS_S_PROBE, RBIS_S_STAT}
        |-> !s_oe_reg)
        else $error("strap driven before init end");
    a_err_record: assert property (
        state_reg == RBIS_S_PROBE && boot_res.rd_err && !halt_s
        ##1 !halt_s |=> stat_reg[`RBIS_ST_RD_ERR])
        else $error("read error not recorded");
    a_pass_thru: assert property (
        state_reg == RBIS_S_FALL && !strap_lvl_reg && !halt_s |=> sdo_reg == $past(sdin_s))
        else $error("test mode does not pass audio");
    a_dflt_quiet: assert property (
        state_reg == RBIS_S_FALL && strap_lvl_reg |-> ##1 sdo_reg == '0)
        else $error("default mode audio out active");
    a_halt_hold: assert property (
        halt_s |=> $stable(state_reg) && !run_reg)
        else $error("state moved while halted");
    a_probe_tmo: assert property (
        state_reg == RBIS_S_PROBE && tmo_reg == TMO_LAST && !halt_s |=> state_reg != RBIS_S_PROBE)
        else $error("probe timeout missed");
    a_addr_sel: assert property (
        ##1 slave_addr == ($past(asel_s) ? `RBIS_SLV_ADDR_B : `RBIS_SLV_ADDR_A))
        else $error("wrong address pair");
endmodule // rbis_seq

// ==== pkg/rbis_cfg.svh ====
// constants for the reset, boot and init sequencer
`ifndef RBIS_CFG_SVH
`define RBIS_CFG_SVH
`define RBIS_CLK_KHZ       50000
`define RBIS_LOAD_TMO_MS   100
`define RBIS_LOAD_TMO_CYC  (`RBIS_LOAD_TMO_MS * `RBIS_CLK_KHZ)
`define RBIS_MEM_DEPTH     16
`define RBIS_SDIO_N        4
`define RBIS_SUB_W         8
`define RBIS_LOAD_STATUS   8'h02
`define RBIS_ST_FOUND      0
`define RBIS_ST_RD_ERR     1
`define RBIS_ST_DONE       2
`define RBIS_ST_TEST       3
`define RBIS_ST_STRAP      4
`define RBIS_ST_BOOTED     5
`define RBIS_SLV_ADDR_A    7'h34
`define RBIS_SLV_ADDR_B    7'h36
`define RBIS_MST_ADDR_A    7'h50
`define RBIS_MST_ADDR_B    7'h51
`endif

// ==== pkg/rbis_pkg.sv ====
// types for the reset, boot and init sequencer
package rbis_pkg;
    typedef struct packed {
        logic probe_done;
        logic found;
        logic load_done;
        logic rd_err;
    } rbis_boot_res_t;

    typedef enum logic [7:0] {
        RBIS_S_IDLE  = 8'h01,
        RBIS_S_CLEAR = 8'h02,
        RBIS_S_PROBE = 8'h04,
        RBIS_S_STAT  = 8'h08,
        RBIS_S_SLV   = 8'h10,
        RBIS_S_DRIVE = 8'h20,
        RBIS_S_FALL  = 8'h40,
        RBIS_S_RUN   = 8'h80
    } rbis_state_t;
endpackage

// ==== tb/rbis_boot_partner.sv ====
// boot memory and system controller model facing the sequencer
`timescale 1ns/1ps
module rbis_boot_partner (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    input  wire logic                master_en,
    input  wire logic                strap_oe,
    input  wire logic                strap_out,
    input  wire logic                strap_pull,
    input  wire logic [1:0]          mode,
    input  wire logic [7:0]          answer_dly,
    output rbis_pkg::rbis_boot_res_t boot_res,
    output logic                     strap_level,
    output logic                     strap_fell
);
    import rbis_pkg::*;
    // result per mode: none, loaded, read error, silent (forces the timeout)
    localparam logic [15:0] RES_TAB = 16'h0DE8;
    logic [7:0] wait_reg;
    logic       last_reg;
    // an undriven strap pin settles to the resistor level
    assign strap_level = strap_oe ? strap_out : strap_pull;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg   <= 8'h00;
            last_reg   <= 1'b0;
            strap_fell <= 1'b0;
            boot_res   <= '0;
        end else begin
            last_reg <= strap_level;
            // the controller only acts after the strap high-to-low edge
            if (last_reg && !strap_level) begin
                strap_fell <= 1'b1;
            end
            if (master_en && wait_reg != answer_dly) begin
                wait_reg <= wait_reg + 8'h01;
            end
            // slow or prompt answer, released while the port is off
            boot_res <= (master_en && wait_reg == answer_dly) ? RES_TAB[mode*4 +: 4] : '0;
        end
    end
endmodule // rbis_boot_partner

// ==== tb/test_reset_boot_init_sequencer.sv ====
// self-checking bench for the reset, boot and init sequencer
`timescale 1ns/1ps
`include "rbis_cfg.svh"
module test_reset_boot_init_sequencer;
    import rbis_pkg::*;
    logic           sys_clk, rst_b, supply_ok_b, clock_halt_input_b, address_select_pin;
    logic           strap_in, strap_pull, strap_fell, slave_dl_done, fw_strap_oe, fw_strap_out;
    logic           strap_out, strap_oe, master_en, slave_en, clk_run, core_idle;
    logic           mcu_init, mem_clr_we, regs_default;
    logic [1:0]     mode;
    logic [3:0]     serial_audio_in, core_audio_out, serial_audio_out, mem_clr_addr;
    logic [6:0]     slave_addr, master_addr;
    logic [7:0]     answer_dly, sub_addr;
    logic [31:0]    sub_rd_data;
    rbis_boot_res_t boot_res;
    int             mismatches = 0;
    int             samples_checked = 0;
    int             cycles = 0;
    int             n;

    rbis_seq #(.LOAD_TMO_CYC(50), .MEM_DEPTH(16), .SDIO_N(4)) u_rbis_seq (
        .sys_clk, .rst_b, .supply_ok_b, .clock_halt_input_b, .address_select_pin, .strap_in,
        .boot_res, .slave_dl_done, .fw_strap_oe, .fw_strap_out, .serial_audio_in,
        .core_audio_out, .sub_addr, .sub_rd_data, .serial_audio_out, .strap_out, .strap_oe,
        .master_en, .slave_en, .slave_addr, .master_addr, .clk_run, .core_idle, .mcu_init,
        .mem_clr_we, .mem_clr_addr, .regs_default
    );
    rbis_boot_partner u_rbis_boot_partner (
        .sys_clk, .rst_b, .master_en, .strap_oe, .strap_out, .strap_pull, .mode, .answer_dly,
        .boot_res, .strap_level(strap_in), .strap_fell
    );

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(int k = 1);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(logic [63:0] got, logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // reset stays low well past supply settling; strap level is set meanwhile
    task automatic boot(logic pull, logic [1:0] md, logic [7:0] dly);
        rst_b = 1'b0;
        {strap_pull, mode, answer_dly, fw_strap_oe, serial_audio_in} = {pull, md, dly, 5'h0F};
        tick(8);
        rst_b = 1'b1;
    endtask

    task automatic s_reset;
        tick(8);
        chk(serial_audio_out, 4'h0);
        chk(sub_rd_data, 32'h0);
        chk({master_en, slave_en}, 2'h0);
        chk(strap_oe, 1'b0);
        chk({core_idle, clk_run}, 2'h3);
        chk({slave_addr, master_addr}, {`RBIS_SLV_ADDR_A, `RBIS_MST_ADDR_A});
    endtask

    task automatic s_fall_high;
        int clr;
        int init;
        int sum;
        int stop;
        clr = 0;
        init = 0;
        sum = 0;
        stop = 0;
        boot(1'b1, 2'h0, 8'h00);
        for (n = 0; n < 300 && master_en !== 1'b1; n++) begin
            tick();
            clr += int'(mem_clr_we === 1'b1);
            init += int'({mcu_init, regs_default} === 2'h3);
            sum += (mem_clr_we === 1'b1) ? int'(mem_clr_addr) : 0;
            stop += int'(clk_run !== 1'b1);
        end
        chk(clr, 16);
        chk(sum, 120);
        chk(stop, 0);
        chk(init, 1);
        chk({slave_en, sub_rd_data}, 33'h0);
        for (n = 0; n < 300 && slave_en !== 1'b1; n++) tick();
        chk(strap_oe, 1'b0);
        tick();
        chk({strap_oe, strap_out}, 2'h2);
        tick(4);
        chk(serial_audio_out, 4'h0);
        chk(sub_rd_data & 32'h1B, 32'h10);
        chk(strap_fell, 1'b1);
        slave_dl_done = 1'b1;
        tick();
        {slave_dl_done, fw_strap_oe, fw_strap_out} = 3'h3;
        tick(3);
        chk({strap_oe, strap_out}, 2'h3);
    endtask

    task automatic s_test_mode;
        boot(1'b0, 2'h2, 8'h14);
        for (n = 0; n < 300 && slave_en !== 1'b1; n++) tick();
        tick(2);
        chk({strap_oe, strap_out}, 2'h2);
        chk(sub_rd_data & 32'h1B, 32'h0B);
        serial_audio_in = 4'hA;
        tick(4);
        chk(serial_audio_out, 4'hA);
        serial_audio_in = 4'h5;
        tick(4);
        chk(serial_audio_out, 4'h5);
    endtask

    task automatic s_timeout;
        boot(1'b1, 2'h3, 8'h00);
        for (n = 0; n < 300 && master_en !== 1'b1; n++) tick();
        for (n = 0; n < 300 && slave_en !== 1'b1; n++) tick();
        chk(n >= 50 && n <= 55, 1'b1);
        tick(2);
        chk(sub_rd_data & 32'h1B, 32'h10);
    endtask

    task automatic s_boot_ok;
        boot(1'b1, 2'h1, 8'h05);
        for (n = 0; n < 300 && core_idle !== 1'b0; n++) tick();
        chk({core_idle, strap_oe}, 2'h0);
        chk(sub_rd_data & 32'h3B, 32'h31);
        chk(serial_audio_out, 4'h6);
        {fw_strap_oe, fw_strap_out} = 2'h2;
        tick(3);
        chk({strap_oe, strap_out}, 2'h2);
        address_select_pin = 1'b1;
        tick(4);
        chk({slave_addr, master_addr}, {`RBIS_SLV_ADDR_B, `RBIS_MST_ADDR_B});
        clock_halt_input_b = 1'b0;
        tick(4);
        chk(clk_run, 1'b0);
        clock_halt_input_b = 1'b1;
        tick(4);
        chk(clk_run, 1'b1);
        supply_ok_b = 1'b0;
        tick();
        chk({master_en, core_idle}, 2'h1);
        supply_ok_b = 1'b1;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // a hung wait ends the run as a failure
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        {rst_b, supply_ok_b, clock_halt_input_b, address_select_pin} = 4'h6;
        {strap_pull, slave_dl_done, fw_strap_oe, fw_strap_out} = 4'h8;
        {mode, answer_dly, sub_addr} = {10'h000, `RBIS_LOAD_STATUS};
        {serial_audio_in, core_audio_out} = 8'hF6;
        s_reset();
        s_fall_high();
        s_test_mode();
        s_timeout();
        s_boot_ok();
        complete_run();
    end
endmodule // test_reset_boot_init_sequencer
